// ### design/afm_pkg.sv
// What this block does
// - Internal termination on raises driver current by 1.6x.
// - Overflow flag high for inputs above or below full scale.
// - Overflow flag delayed through the same pipeline as its word.
// - Full-rate CMOS data changes on falling output clock edge.
// - Both DDR modes update data lines on both output clock edges.
// - Output clock delayed by 0, 45, 90 or 135 degrees with the stabilizer on.
// - Polarity bit inverts output clock independent of phase.
// - Reset format is offset binary, zero input gives midscale code.
// - Two's complement selectable, zero input gives all zeros.
// - Out-of-range inputs clamp to max or min code of format.
// - Randomizer XORs every bit above LSB with the LSB.
// - Randomizer leaves LSB, overflow flag and output clock alone.
// - Alternate polarity independent of randomizer, forces offset binary.
// - Test patterns: ones, zeros, alternating, checkerboard.
// - Test pattern overrides all other formatting.
// - Output disable puts every digital output in high impedance.
// - Sleep by register or pin powers down; output valid 2 ms after.
// - Nap keeps references; 100 clocks recovery, 50 us DC settling.
// - Clock timing bit 3 selects output clock polarity.
package afm_pkg;
    localparam int          CLK_MHZ        = 40;
    localparam logic [11:0] ADDR_PWR       = 12'h000;
    localparam logic [11:0] ADDR_CLK       = 12'h004;
    localparam logic [11:0] ADDR_DRV       = 12'h008;
    localparam logic [11:0] ADDR_FMT       = 12'h00c;
    localparam logic [11:0] ADDR_STAT      = 12'h010;
    localparam logic [7:0]  RST_REG        = 8'h00;
    localparam int          CT_DCS         = 0;
    localparam int          CT_PH          = 1;
    localparam int          CT_INV         = 3;
    localparam int          DRV_DIS        = 0;
    localparam int          DRV_TERM       = 1;
    localparam int          DRV_CUR        = 2;
    localparam int          DRV_MODE       = 5;
    localparam int          FMT_TWOS       = 0;
    localparam int          FMT_RAND       = 1;
    localparam int          FMT_ABP        = 2;
    localparam int          FMT_TP_EN      = 3;
    localparam int          FMT_TP         = 4;
    localparam logic [1:0]  PD_NAP         = 2'h1;
    localparam logic [1:0]  PD_SLEEP       = 2'h3;
    localparam int          PHASES         = 8;
    localparam int          PIPE_DEPTH     = 3;
    localparam int          SLEEP_WAKE_US  = 2000;
    localparam int          NAP_WAKE_CLKS  = 100;
    localparam int          DC_SETTLE_US   = 50;
    localparam int          SLEEP_WAKE_CYC = SLEEP_WAKE_US * CLK_MHZ;
    localparam int          NAP_WAKE_CYC   = NAP_WAKE_CLKS * PHASES;
    localparam int          DC_SETTLE_CYC  = DC_SETTLE_US * CLK_MHZ;
    localparam logic [13:0] MAX_CODE       = 14'h3fff;
    localparam logic [13:0] MIN_CODE       = 14'h0000;
    localparam logic [13:0] ODD_BITS       = 14'h2aaa;
    localparam logic [14:0] TP_CHECK_A     = 15'h5555;
    localparam logic [14:0] TP_CHECK_B     = 15'h2aaa;

    typedef enum logic [1:0] {
        PS_RUN   = 2'b00,
        PS_NAP   = 2'b01,
        PS_SLEEP = 2'b10,
        PS_WAKE  = 2'b11
    } afm_pwr_t;

    typedef enum logic [1:0] {
        OM_CMOS     = 2'b00,
        OM_DDR_CMOS = 2'b01,
        OM_DDR_LVDS = 2'b10
    } afm_omode_t;

    typedef enum logic [1:0] {
        TP_ONES  = 2'b00,
        TP_ZEROS = 2'b01,
        TP_ALT   = 2'b10,
        TP_CHECK = 2'b11
    } afm_tp_t;

    // Driver current in steps of 0.05 mA
    function automatic logic [8:0] afm_cur_base(input logic [2:0] sel);
        case (sel)
            3'h1:    afm_cur_base = 9'h050;
            3'h2:    afm_cur_base = 9'h05a;
            3'h4:    afm_cur_base = 9'h03c;
            3'h5:    afm_cur_base = 9'h032;
            3'h6:    afm_cur_base = 9'h02a;
            3'h7:    afm_cur_base = 9'h023;
            default: afm_cur_base = 9'h046;
        endcase
    endfunction
endpackage

// ### design/afm_pipe.sv
`timescale 1ns/100ps
module afm_pipe
    import afm_pkg::*;
#(
    parameter int W     = 15,
    parameter int DEPTH = PIPE_DEPTH
)(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // Stream
    input  wire logic         adv,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage_ff [DEPTH];

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < DEPTH; i++)
                stage_ff[i] <= '0;
        end
        else if (adv)
        begin
            stage_ff[0] <= din;
            for (int i = 1; i < DEPTH; i++)
                stage_ff[i] <= stage_ff[i-1];
        end
    end

    assign dout = stage_ff[DEPTH-1];
endmodule

// ### design/afm_clkgen.sv
`timescale 1ns/100ps
module afm_clkgen
    import afm_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Control
    input  wire logic       run,
    input  wire logic [2:0] nxt_cnt,
    input  wire logic [1:0] shift,
    input  wire logic       invert,
    // Clock out
    output logic            clk_out
);
    logic       clk_ff;
    logic [2:0] ph;

    // One count is one eighth of a sample, so a shift step is 45 degrees
    assign ph = nxt_cnt - {1'b0, shift};

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            clk_ff <= 1'b0;
        else
            clk_ff <= run & (ph[2] ^ invert);
    end

    assign clk_out = clk_ff;
endmodule

// ### design/afm_output_formatter.sv
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module afm_output_formatter
    import afm_pkg::*;
#(
    parameter int SLEEP_WAKE = SLEEP_WAKE_CYC
)(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Converter core
    input  wire logic [13:0] core_code,
    input  wire logic        core_over,
    input  wire logic        core_under,
    input  wire logic        sleep_pin,
    output logic             core_pd,
    output logic             dcs_en,
    // Driver control
    output logic      [8:0]  drive_current,
    output logic             term_en,
    output logic      [1:0]  out_mode,
    // Output pins
    output logic      [13:0] converted_word,
    output logic             overflow_flag,
    output logic             output_sample_clock,
    output logic             out_oe_n
);
    logic [7:0]  power_down_register_ff;
    logic [7:0]  clock_timing_register_ff;
    logic [7:0]  output_driver_register_ff;
    logic [7:0]  data_format_register_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        sleep_s1_ff;
    logic        sleep_s2_ff;
    afm_pwr_t    state_ff;
    afm_pwr_t    nxt_state;
    logic        from_sleep_ff;
    logic [16:0] wake_cnt_ff;
    logic        settled_ff;
    logic [2:0]  cnt_ff;
    logic [2:0]  nxt_cnt;
    logic        alt_ph_ff;
    logic [14:0] hold_ff;
    logic [13:0] word_ff;
    logic        of_ff;
    logic        oe_n_ff;
    logic [8:0]  cur_ff;
    logic        core_pd_ff;
    logic        dcs_ff;
    logic        term_ff;
    logic [1:0]  mode_ff;
    logic        running;
    logic        sample_tick;
    logic        sleep_req;
    logic        nap_req;
    logic [1:0]  eff_shift;
    logic        acc;
    logic        hit;
    logic [31:0] rd_mux;
    logic        flag;
    logic [13:0] clamped;
    logic [13:0] fw;
    logic [14:0] pipe_in;
    logic [14:0] pipe_out;
    logic [6:0]  even_bits;
    logic [6:0]  odd_bits;
    logic [11:0] cur_scaled;
    logic [16:0] wake_target;
    logic        twos;
    logic        rnd;
    logic        abp;
    logic        tp_en;
    afm_tp_t     tp_sel;

    assign twos   = data_format_register_ff[FMT_TWOS];
    assign rnd    = data_format_register_ff[FMT_RAND];
    assign abp    = data_format_register_ff[FMT_ABP];
    assign tp_en  = data_format_register_ff[FMT_TP_EN];
    assign tp_sel = afm_tp_t'(data_format_register_ff[FMT_TP +: 2]);

    // APB: pready rises one cycle into the access phase; writes commit on the next edge
    assign acc = psel & penable & pready_ff;
    assign hit = (paddr == ADDR_PWR) | (paddr == ADDR_CLK) | (paddr == ADDR_DRV)
               | (paddr == ADDR_FMT) | (paddr == ADDR_STAT);

    always_comb
    begin
        rd_mux = 32'h0;
        case (paddr)
            ADDR_PWR:  rd_mux[7:0] = power_down_register_ff;
            ADDR_CLK:  rd_mux[7:0] = clock_timing_register_ff;
            ADDR_DRV:  rd_mux[7:0] = output_driver_register_ff;
            ADDR_FMT:  rd_mux[7:0] = data_format_register_ff;
            ADDR_STAT: rd_mux[4:0] = {(eff_shift != clock_timing_register_ff[CT_PH +: 2]),
                                      settled_ff, running, state_ff};
            default:   rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end
        else
        begin
            pready_ff  <= psel & penable & ~pready_ff;
            pslverr_ff <= psel & penable & ~pready_ff & ~hit;
            if (psel & penable & ~pready_ff & ~pwrite)
                prdata_ff <= rd_mux;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            power_down_register_ff    <= RST_REG;
            clock_timing_register_ff  <= RST_REG;
            output_driver_register_ff <= RST_REG;
            data_format_register_ff   <= RST_REG;
        end
        else if (acc & pwrite)
        begin
            case (paddr)
                ADDR_PWR: power_down_register_ff    <= pwdata[7:0];
                ADDR_CLK: clock_timing_register_ff  <= pwdata[7:0];
                ADDR_DRV: output_driver_register_ff <= pwdata[7:0];
                ADDR_FMT: data_format_register_ff   <= pwdata[7:0];
                default:  ;
            endcase
        end
    end

    // Sleep pin comes from a board level strap or logic, so synchronise it
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sleep_s1_ff <= 1'b0;
            sleep_s2_ff <= 1'b0;
        end
        else
        begin
            sleep_s1_ff <= sleep_pin;
            sleep_s2_ff <= sleep_s1_ff;
        end
    end

    assign sleep_req   = sleep_s2_ff | (power_down_register_ff[1:0] == PD_SLEEP);
    assign nap_req     = ~sleep_req & (power_down_register_ff[1:0] == PD_NAP);
    assign wake_target = from_sleep_ff ? 17'(SLEEP_WAKE) : 17'(NAP_WAKE_CYC);
    assign running     = (state_ff == PS_RUN);

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            PS_RUN:   if (sleep_req) nxt_state = PS_SLEEP;
                      else if (nap_req) nxt_state = PS_NAP;
            PS_NAP:   if (sleep_req) nxt_state = PS_SLEEP;
                      else if (!nap_req) nxt_state = PS_WAKE;
            PS_SLEEP: if (!sleep_req) nxt_state = PS_WAKE;
            PS_WAKE:  if (sleep_req) nxt_state = PS_SLEEP;
                      else if (nap_req) nxt_state = PS_NAP;
                      else if (wake_cnt_ff + 17'h1 >= wake_target) nxt_state = PS_RUN;
            default:  nxt_state = PS_RUN;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            state_ff <= PS_RUN;
        else
            state_ff <= nxt_state;
    end

    // Counter keeps going after a nap so the DC settling time is reported too
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            from_sleep_ff <= 1'b0;
            wake_cnt_ff   <= 17'h0;
            settled_ff    <= 1'b1;
        end
        else if (state_ff == PS_SLEEP || state_ff == PS_NAP)
        begin
            from_sleep_ff <= (state_ff == PS_SLEEP);
            wake_cnt_ff   <= 17'h0;
            settled_ff    <= 1'b0;
        end
        else if (!settled_ff)
        begin
            wake_cnt_ff <= wake_cnt_ff + 17'h1;
            if (running && (from_sleep_ff ||
                wake_cnt_ff >= 17'(NAP_WAKE_CYC + DC_SETTLE_CYC)))
                settled_ff <= 1'b1;
        end
    end

    // Eight core cycles per sample give the 45 degree phase steps
    assign nxt_cnt     = cnt_ff + 3'h1;
    assign sample_tick = running & (cnt_ff == 3'h7);

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            cnt_ff <= 3'h0;
        else
            cnt_ff <= nxt_cnt;
    end

    // Phase shift is only valid with the stabilizer running
    assign eff_shift = clock_timing_register_ff[CT_DCS]
                     ? clock_timing_register_ff[CT_PH +: 2] : 2'h0;

    afm_clkgen u_clkgen (
        .core_clk (core_clk),
        .rstn     (rstn),
        .run      (running),
        .nxt_cnt  (nxt_cnt),
        .shift    (eff_shift),
        .invert   (clock_timing_register_ff[CT_INV]),
        .clk_out  (output_sample_clock)
    );

    // Sample formatting, applied before the pipeline so flag and word share it
    assign flag    = core_over | core_under;
    assign clamped = core_over ? MAX_CODE : (core_under ? MIN_CODE : core_code);

    always_comb
    begin
        fw = clamped;
        if (twos && !abp)
            fw[13] = ~fw[13];
        if (rnd)
            fw[13:1] = fw[13:1] ^ {13{fw[0]}};
        if (abp)
            fw = fw ^ ODD_BITS;
        pipe_in = {flag, fw};
        if (tp_en)
        begin
            case (tp_sel)
                TP_ONES:  pipe_in = 15'h7fff;
                TP_ZEROS: pipe_in = 15'h0000;
                TP_ALT:   pipe_in = alt_ph_ff ? 15'h0000 : 15'h7fff;
                TP_CHECK: pipe_in = alt_ph_ff ? TP_CHECK_B : TP_CHECK_A;
                default:  pipe_in = 15'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            alt_ph_ff <= 1'b0;
        else if (sample_tick)
            alt_ph_ff <= ~alt_ph_ff;
    end

    afm_pipe #(.W(15), .DEPTH(PIPE_DEPTH)) u_pipe (
        .core_clk (core_clk),
        .rstn     (rstn),
        .adv      (sample_tick),
        .din      (pipe_in),
        .dout     (pipe_out)
    );

    always_comb
    begin
        for (int i = 0; i < 7; i++)
        begin
            even_bits[i] = pipe_out[2*i];
            odd_bits[i]  = hold_ff[2*i+1];
        end
    end

    // Output word updates as the unshifted clock falls; DDR also as it rises
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hold_ff <= 15'h0;
            word_ff <= 14'h0;
            of_ff   <= 1'b0;
        end
        else if (nxt_cnt == 3'h0)
        begin
            hold_ff <= pipe_out;
            of_ff   <= pipe_out[14];
            if (mode_ff == OM_CMOS)
                word_ff <= pipe_out[13:0];
            else
                word_ff <= {7'h0, even_bits};
        end
        else if (nxt_cnt == 3'h4 && mode_ff != OM_CMOS)
            word_ff <= {7'h0, odd_bits};
    end

    assign cur_scaled = {3'h0, afm_cur_base(output_driver_register_ff[DRV_CUR +: 3])};

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            oe_n_ff    <= 1'b1;
            cur_ff     <= 9'h0;
            core_pd_ff <= 1'b0;
            dcs_ff     <= 1'b0;
            term_ff    <= 1'b0;
            mode_ff    <= OM_CMOS;
        end
        else
        begin
            oe_n_ff    <= output_driver_register_ff[DRV_DIS];
            term_ff    <= output_driver_register_ff[DRV_TERM];
            mode_ff    <= output_driver_register_ff[DRV_MODE +: 2];
            cur_ff     <= output_driver_register_ff[DRV_TERM]
                        ? 9'((cur_scaled * 12'h8) / 12'h5) : cur_scaled[8:0];
            core_pd_ff <= (state_ff == PS_SLEEP) | (state_ff == PS_NAP);
            dcs_ff     <= clock_timing_register_ff[CT_DCS];
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign converted_word = word_ff;
    assign overflow_flag  = of_ff;
    assign out_oe_n       = oe_n_ff;
    assign drive_current  = cur_ff;
    assign term_en        = term_ff;
    assign out_mode       = mode_ff;
    assign core_pd        = core_pd_ff;
    assign dcs_en         = dcs_ff;

    logic [4:0] run_len_ff;
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            run_len_ff <= 5'h0;
        else if (!running)
            run_len_ff <= 5'h0;
        else if (run_len_ff != 5'h1f)
            run_len_ff <= run_len_ff + 5'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_plain_tick;
        sample_tick && !tp_en && !rnd && !abp;
    endsequence

    a_clamp_over_flag: assert property (s_plain_tick ##0 core_over
        |-> pipe_in == {1'b1, MAX_CODE ^ {twos, 13'h0}}) else $error("overrange not clamped");
    a_offset_default: assert property (s_plain_tick ##0 (!twos && !flag)
        |-> pipe_in == {1'b0, core_code}) else $error("offset binary wrong");
    a_twos_msb_flip: assert property (s_plain_tick ##0 (twos && !flag)
        |-> pipe_in[13:0] == (core_code ^ 14'h2000)) else $error("twos format wrong");
    a_rand_keeps_lsb: assert property ((sample_tick && rnd && !tp_en)
        |-> pipe_in[0] == clamped[0] && pipe_in[14] == flag) else $error("randomizer touched lsb");
    a_abp_forces_ob: assert property ((sample_tick && abp && !rnd && !tp_en)
        |-> pipe_in[13:0] == (clamped ^ ODD_BITS)) else $error("alternate polarity wrong");
    a_tp_ones_wins: assert property ((sample_tick && tp_en && tp_sel == TP_ONES)
        |-> pipe_in == 15'h7fff) else $error("test pattern overridden");
    a_oe_follows_dis: assert property ($rose(output_driver_register_ff[DRV_DIS])
        |=> out_oe_n ##1 out_oe_n) else $error("outputs not disabled");
    a_flag_word_align: assert property ((sample_tick && run_len_ff > 5'd24)
        |-> pipe_out == $past(pipe_in, 24)) else $error("flag and word misaligned");
    a_cmos_falling: assert property (($changed(converted_word) && running
        && $past(running) && mode_ff == OM_CMOS && $stable(mode_ff) && eff_shift == 2'h0
        && !clock_timing_register_ff[CT_INV] && $stable(clock_timing_register_ff))
        |-> $fell(output_sample_clock)) else $error("data not on falling edge");
    a_nap_recover: assert property (($past(state_ff) == PS_WAKE && running
        && !from_sleep_ff) |-> wake_cnt_ff >= 17'(NAP_WAKE_CYC - 1))
        else $error("nap recovery too short");
endmodule

// ### bench/afm_rx.sv
`timescale 1ns/100ps
module afm_rx
    import afm_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // Link from the converter
    input  wire logic        link_clk,
    input  wire logic [13:0] link_word,
    input  wire logic        link_of,
    // Captured sample
    output logic      [13:0] cap_word_ff,
    output logic             cap_of_ff
);
    logic link_clk_ff;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            link_clk_ff <= 1'b0;
        else
            link_clk_ff <= link_clk;
    end

    // Full-rate CMOS: take the word on the rising output clock edge, mid-eye
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cap_word_ff <= 14'h0000;
            cap_of_ff   <= 1'b0;
        end
        else if (link_clk && !link_clk_ff)
        begin
            cap_word_ff <= link_word;
            cap_of_ff   <= link_of;
        end
    end
endmodule

// ### bench/afm_output_formatter_tb.sv
`timescale 1ns/100ps
module afm_output_formatter_tb
    import afm_pkg::*;
;
    logic        core_clk, rstn, psel, penable, pwrite, core_over, core_under, sleep_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] core_code, converted_word, cap_word, w_ddr;
    logic        dcs;
    logic [1:0]  omode;
    logic        pready, pslverr, core_pd, term_en, overflow_flag, clk_o, oe_n, cap_of, err;
    logic [8:0]  drive_current;
    wire  [13:0] pin_word = oe_n ? 14'hzzzz : converted_word;
    wire         pin_of   = oe_n ? 1'bz : overflow_flag;
    wire         pin_clk  = oe_n ? 1'bz : clk_o;
    int          bad_count, n_checks;
    // Pattern table: format value, range flags, raw code, expected word and flag
    logic [7:0]  t_fmt  [8] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h02, 8'h05, 8'h0f, 8'h18};
    logic [1:0]  t_rng  [8] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
    logic [13:0] t_code [8] = '{14'h2000, 14'h2000, 14'h2000, 14'h2000, 14'h2001, 14'h2000,
                                14'h1234, 14'h1234};
    logic [13:0] t_word [8] = '{14'h2000, 14'h0000, 14'h1fff, 14'h0000, 14'h1fff, 14'h0aaa,
                                14'h3fff, 14'h0000};
    logic        t_of   [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

    // Short sleep wake so the power test stays quick
    afm_output_formatter #(.SLEEP_WAKE(20)) u_afm_output_formatter (
        .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_code(core_code), .core_over(core_over), .core_under(core_under),
        .sleep_pin(sleep_pin), .core_pd(core_pd), .dcs_en(dcs), .drive_current(drive_current),
        .term_en(term_en), .out_mode(omode), .converted_word(converted_word),
        .overflow_flag(overflow_flag), .output_sample_clock(clk_o), .out_oe_n(oe_n));

    afm_rx u_afm_rx (.core_clk(core_clk), .rstn(rstn), .link_clk(pin_clk),
        .link_word(pin_word), .link_of(pin_of), .cap_word_ff(cap_word), .cap_of_ff(cap_of));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; waits for pready, no cycle count assumed
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            chk("pready", 0, 1);
        // Idle edge so a following call never lowers and raises psel at once
        @(posedge core_clk);
    endtask

    // Two captures one sample apart must be both pattern halves, in either order
    task automatic pair_chk(input string name, input logic [14:0] a, input logic [14:0] b);
        logic [14:0] w0;
        logic [14:0] w1;
        w0 = {cap_of, cap_word};
        repeat (8) @(posedge core_clk);
        w1 = {cap_of, cap_word};
        chk(name, ({w0, w1} === {a, b}) || ({w0, w1} === {b, a}), 1'b1);
    endtask

    // Core edges from a data change to the next rising output clock edge
    task automatic gap_chk(input logic [7:0] ct, input int exp);
        logic [13:0] w;
        logic        prev;
        int          gap;
        apb(1'b1, ADDR_CLK, {24'h0, ct});
        w = converted_word;
        while (converted_word === w)
            @(posedge core_clk);
        gap = 0;
        do
        begin
            prev = clk_o;
            @(posedge core_clk);
            gap++;
        end
        while (!(clk_o === 1'b1 && prev === 1'b0) && gap < 20);
        chk("clk_gap", gap, exp);
    endtask

    task automatic final_report();
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        final_report();
    end

    initial
    begin
        {rstn, psel, penable, pwrite, core_over, core_under, sleep_pin} = '0;
        {paddr, pwdata, core_code} = '0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, ADDR_FMT, 0);
        chk("fmt_reset", rd, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, ADDR_FMT, {24'h0, t_fmt[i]});
            core_code  <= t_code[i];
            core_over  <= t_rng[i][1];
            core_under <= t_rng[i][0];
            // Pipeline of three samples plus margin before the link is looked at
            repeat (48) @(posedge core_clk);
            chk("word", cap_word, t_word[i]);
            chk("flag", cap_of, t_of[i]);
            if (t_fmt[i][3:1] == 3'b001)
                chk("derand", cap_word ^ {{13{cap_word[0]}}, 1'b0}, t_code[i]);
            if (t_fmt[i][3:2] == 2'b01)
                chk("deabp", cap_word ^ ODD_BITS, t_code[i]);
        end
        apb(1'b1, ADDR_FMT, 32'h28);
        repeat (48) @(posedge core_clk);
        pair_chk("alt", 15'h7fff, 15'h0000);
        gap_chk(8'h04, 4);
        apb(1'b0, ADDR_STAT, 0);
        chk("ph_ignored", rd[4], 1'b1);
        gap_chk(8'h05, 6);
        chk("dcs", dcs, 1'b1);
        gap_chk(8'h0d, 2);
        apb(1'b1, ADDR_CLK, 0);
        apb(1'b1, ADDR_FMT, 32'h38);
        repeat (48) @(posedge core_clk);
        pair_chk("checker", TP_CHECK_A, TP_CHECK_B);
        apb(1'b1, ADDR_FMT, 0);
        core_code <= 14'h1555;
        apb(1'b1, ADDR_DRV, 32'h20);
        repeat (48) @(posedge core_clk);
        chk("mode", omode, 2'h1);
        w_ddr = converted_word;
        repeat (4) @(posedge core_clk);
        chk("ddr_or", w_ddr | converted_word, 14'h007f);
        chk("ddr_xor", w_ddr ^ converted_word, 14'h007f);
        apb(1'b1, ADDR_DRV, 32'h2);
        @(posedge core_clk);
        chk("term", {term_en, drive_current}, 10'h270);
        apb(1'b1, ADDR_DRV, 32'h1);
        repeat (2) @(posedge core_clk);
        chk("hiz", {pin_word === 14'hzzzz, pin_of === 1'bz, pin_clk === 1'bz}, 3'h7);
        apb(1'b0, 12'h020, 0);
        chk("unmapped_err", err, 1'b1);
        chk("unmapped_rd", rd, 32'h0);
        apb(1'b1, ADDR_PWR, {30'h0, PD_SLEEP});
        repeat (4) @(posedge core_clk);
        chk("sleep", core_pd, 1'b1);
        apb(1'b1, ADDR_PWR, 0);
        repeat (40) @(posedge core_clk);
        apb(1'b0, ADDR_STAT, 0);
        chk("awake", rd[1:0], 2'h0);
        sleep_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk("pin_sleep", core_pd, 1'b1);
        sleep_pin <= 1'b0;
        repeat (40) @(posedge core_clk);
        apb(1'b1, ADDR_PWR, {30'h0, PD_NAP});
        repeat (4) @(posedge core_clk);
        chk("nap", core_pd, 1'b1);
        apb(1'b1, ADDR_PWR, 0);
        apb(1'b0, ADDR_STAT, 0);
        chk("nap_wake", rd[1:0], 2'h3);
        repeat (NAP_WAKE_CYC) @(posedge core_clk);
        apb(1'b0, ADDR_STAT, 0);
        chk("nap_run", rd[3:0], 4'h4);
        repeat (DC_SETTLE_CYC + 40) @(posedge core_clk);
        apb(1'b0, ADDR_STAT, 0);
        chk("nap_settled", rd[3], 1'b1);
        final_report();
    end
endmodule
